/* include/rrx_regs.vh */
// Purpose: Constants for the repeat, return and rotate execution block.
// Assumes: 16-bit datapath, 16-bit flags word in the usual bit order.
// Notes: Flag positions, step sizes, reset word and primitive codes only; the block has no registers of its own.
`ifndef RRX_REGS_VH
`define RRX_REGS_VH
`define RRX_FLAG_CF 0
`define RRX_FLAG_ZF 6
`define RRX_FLAG_OF 11
`define RRX_POP_STEP 16'h0002
`define RRX_CNT_STEP 16'h0001
`define RRX_RST_WORD 16'h0000
`define RRX_PRIM_MOVE 2'h0
`define RRX_PRIM_STORE 2'h1
`define RRX_PRIM_CMP 2'h2
`define RRX_PRIM_SCAN 2'h3
`endif

/* src/rrx_rotl.v */
// Purpose: Rotate-left datapath, one step per count, byte or word.
// Assumes: Caller holds inputs stable; the output follows them combinationally, there is no step input.
// Notes: Carry and the result high bit are the only flag inputs produced; overflow is formed by the caller.
`timescale 1ns/1ns
`include "rrx_regs.vh"
module rrx_rotl (
   // Operand
   input wire [15:0] data_in,
   input wire word_sel,
   // Result
   output wire [15:0] data_out,
   output wire carry_out,
   output wire high_bit
);
   wire msb;
   assign msb = word_sel ? data_in[15] : data_in[7];
   // Outgoing high bit re-enters at the low end; see RL9
   assign data_out = word_sel ? {data_in[14:0], data_in[15]} : {8'h00, data_in[6:0], data_in[7]};
   assign carry_out = msb;
   assign high_bit = word_sel ? data_out[15] : data_out[7];
endmodule

/* src/rrx_stack_pop.v */
// Purpose: Stack pointer arithmetic for the return sequence.
// Assumes: Pop value is already zero-extended by rrx_exec from the 8-bit ret_pop_value.
// Notes: Pure combinational adders.
`timescale 1ns/1ns
`include "rrx_regs.vh"
module rrx_stack_pop (
   // Inputs
   input wire [15:0] sp_in,
   input wire [15:0] pop_value,
   // Outputs
   output wire [15:0] sp_popped,
   output wire [15:0] sp_adjusted
);
   assign sp_popped = sp_in + `RRX_POP_STEP;
   assign sp_adjusted = sp_in + pop_value;
endmodule

/* src/rrx_exec.v */
// Purpose: Executes repeated string prefixes, procedure returns and rotate-left.
// Assumes: Primitive engine, interrupt logic and stack memory reply on the same clock.
// Notes: Flags pass through untouched except carry and overflow on rotate-left and primitive results on repeat.
// Notes on behaviour
// RL1 - A plain repeat before move or store string keeps repeating while the count register is nonzero.
// RL2 - Repeat-while-equal shares the plain repeat byte and with compare or scan continues only if zero flag is set.
// RL3 - Repeat-while-not-equal has its own byte and with compare or scan stops unless zero flag is clear.
// RL4 - The zero flag before the first iteration is never looked at; only each primitive's result counts.
// RL5 - Each iteration services a pending interrupt, runs the primitive once, decrements count, then tests.
// RL6 - A return loads the instruction pointer from the stack top word and adds two to the stack pointer.
// RL7 - A far return then loads the code segment from the new top word and adds two again; near pops once.
// RL8 - A return with a pop value adds that value to the stack pointer after the address pops.
// RL9 - Rotate-left moves the operand left once per count step, high bit into carry and into bit zero.
// RL10 - With count one overflow is set when result high bit differs from carry, else cleared.
// RL11 - Rotate-left changes only carry and overflow.
// RL12 - Repeat prefixes and return leave every flag unchanged apart from primitive results.
`timescale 1ns/1ns
`include "rrx_regs.vh"
module rrx_exec (
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // Command
   input wire start_rep,
   input wire rep_while_zero,
   input wire [1:0] prim_kind,
   input wire start_ret,
   input wire ret_far,
   input wire ret_has_pop,
   input wire [7:0] ret_pop_value,
   input wire start_rotl,
   input wire rotl_word,
   input wire [7:0] rotl_count,
   input wire [15:0] rotl_operand,
   output wire busy,
   output reg done_q,
   // Architectural state in
   input wire [15:0] count_in,
   input wire [15:0] sp_in,
   input wire [15:0] flags_in,
   // Interrupt service handshake
   input wire irq_pending,
   output wire irq_service_req,
   input wire irq_service_done,
   // Primitive engine handshake
   output wire prim_req,
   input wire prim_done,
   input wire [15:0] prim_flags,
   // Stack read handshake
   output wire stack_rd_req,
   output reg [15:0] stack_addr_q,
   input wire stack_rd_done,
   input wire [15:0] stack_rd_data,
   // Results
   output reg [15:0] count_out_q,
   output reg [15:0] sp_out_q,
   output reg [15:0] ip_out_q,
   output reg [15:0] cs_out_q,
   output reg cs_load_q,
   output reg [15:0] flags_out_q,
   output reg [15:0] rotl_result_q
);
   // ------------------------------------------------------------
   // Sequencer states, one-hot.
   // ------------------------------------------------------------
   localparam [8:0] ST_IDLE = 9'h001;
   localparam [8:0] ST_REP_TEST = 9'h002;
   localparam [8:0] ST_REP_IRQ = 9'h004;
   localparam [8:0] ST_REP_PRIM = 9'h008;
   localparam [8:0] ST_RET_IP = 9'h010;
   localparam [8:0] ST_RET_CS = 9'h020;
   localparam [8:0] ST_RET_ADJ = 9'h040;
   localparam [8:0] ST_ROTL = 9'h080;
   localparam [8:0] ST_DONE = 9'h100;

   // ------------------------------------------------------------
   // Captured command and working state.
   // ------------------------------------------------------------
   // Operands are captured at the start, so the caller need not hold them.
   reg [8:0] state_q;
   reg rep_zero_q;
   reg rep_cmp_q;
   reg ret_far_q;
   reg ret_pop_q;
   reg [15:0] pop_q;
   reg word_q;
   reg [7:0] steps_q;
   reg one_step_q;
   wire [15:0] rot_next;
   wire rot_carry;
   wire rot_high;
   wire [15:0] sp_popped;
   wire [15:0] sp_adjusted;

   // ------------------------------------------------------------
   // Continuation test on a primitive's posted zero flag.
   // ------------------------------------------------------------
   // Move and store never look at the zero flag; only compare and scan do.
   function cont_ok;
      input cmp_kind;
      input want_zero;
      input zf;
      begin
         if (!cmp_kind) begin
            cont_ok = 1'b1;
         end else if (want_zero) begin
            cont_ok = zf;
         end else begin
            cont_ok = ~zf;
         end
      end
   endfunction

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // The rotator works on the held result, so each step feeds the next.
   rrx_rotl u_rotl (
      .data_in(rotl_result_q),
      .word_sel(word_q),
      .data_out(rot_next),
      .carry_out(rot_carry),
      .high_bit(rot_high)
   );

   // ------------------------------------------------------------
   // Stack pointer adders.
   // ------------------------------------------------------------
   rrx_stack_pop u_pop (
      .sp_in(sp_out_q),
      .pop_value(pop_q),
      .sp_popped(sp_popped),
      .sp_adjusted(sp_adjusted)
   );

   // ------------------------------------------------------------
   // Flags word after one rotate step.
   // ------------------------------------------------------------
   reg [15:0] rot_flags_d;
   always @* begin
      rot_flags_d = flags_out_q;
      // Outgoing high bit lands in carry; see RL9
      rot_flags_d[`RRX_FLAG_CF] = rot_carry;
      // Overflow defined only for a single step; see RL10
      if (one_step_q) begin
         rot_flags_d[`RRX_FLAG_OF] = rot_high ^ rot_carry;
      end
   end

   // ------------------------------------------------------------
   // Loop continuation after a primitive.
   // ------------------------------------------------------------
   wire rep_go_on;
   assign rep_go_on = cont_ok(rep_cmp_q, rep_zero_q, prim_flags[`RRX_FLAG_ZF]);

   // ------------------------------------------------------------
   // Request and status outputs.
   // ------------------------------------------------------------
   // Requests are decoded from the state, so each drops in the cycle after its answer; on a far return the stack read stays high into the code segment read.
   // Busy is already low in the done cycle, so the next start may come beside done.
   assign busy = (state_q != ST_IDLE);
   assign irq_service_req = (state_q == ST_REP_IRQ);
   assign prim_req = (state_q == ST_REP_PRIM);
   assign stack_rd_req = (state_q == ST_RET_IP) || (state_q == ST_RET_CS);

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         state_q <= ST_IDLE;
         rep_zero_q <= 1'b0;
         rep_cmp_q <= 1'b0;
         ret_far_q <= 1'b0;
         ret_pop_q <= 1'b0;
         pop_q <= `RRX_RST_WORD;
         word_q <= 1'b0;
         steps_q <= 8'h00;
         one_step_q <= 1'b0;
         done_q <= 1'b0;
         stack_addr_q <= `RRX_RST_WORD;
         count_out_q <= `RRX_RST_WORD;
         sp_out_q <= `RRX_RST_WORD;
         ip_out_q <= `RRX_RST_WORD;
         cs_out_q <= `RRX_RST_WORD;
         cs_load_q <= 1'b0;
         flags_out_q <= `RRX_RST_WORD;
         rotl_result_q <= `RRX_RST_WORD;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               // Starts are looked at only here, so one that comes while busy is dropped.
               if (start_rep) begin
                  // Zero flag is only judged after a primitive posts it; see RL4
                  rep_zero_q <= rep_while_zero;
                  rep_cmp_q <= prim_kind[1];
                  count_out_q <= count_in;
                  flags_out_q <= flags_in;
                  state_q <= ST_REP_TEST;
               end else if (start_ret) begin
                  ret_far_q <= ret_far;
                  ret_pop_q <= ret_has_pop;
                  pop_q <= {8'h00, ret_pop_value};
                  sp_out_q <= sp_in;
                  stack_addr_q <= sp_in;
                  cs_load_q <= 1'b0;
                  // Return never alters flags; see RL12
                  flags_out_q <= flags_in;
                  state_q <= ST_RET_IP;
               end else if (start_rotl) begin
                  word_q <= rotl_word;
                  steps_q <= rotl_count;
                  one_step_q <= (rotl_count == 8'h01);
                  rotl_result_q <= rotl_word ? rotl_operand : {8'h00, rotl_operand[7:0]};
                  // Everything except carry and overflow is carried over; see RL11
                  flags_out_q <= flags_in;
                  state_q <= ST_ROTL;
               end
            end
            ST_REP_TEST: begin
               // Loop while the count is nonzero; see RL1
               if (count_out_q == `RRX_RST_WORD) begin
                  state_q <= ST_DONE;
               end else if (irq_pending) begin
                  // The interrupt is looked at once per iteration, after the count test.
                  // Pending interrupt is serviced before the primitive; see RL5
                  state_q <= ST_REP_IRQ;
               end else begin
                  state_q <= ST_REP_PRIM;
               end
            end
            ST_REP_IRQ: begin
               if (irq_service_done) begin
                  state_q <= ST_REP_PRIM;
               end
            end
            ST_REP_PRIM: begin
               if (prim_done) begin
                  // Only the primitive may change flags; see RL12
                  flags_out_q <= prim_flags;
                  // Decrement before the loop test; see RL5
                  count_out_q <= count_out_q - `RRX_CNT_STEP;
                  // Equal form needs zero set, not-equal form needs it clear; see RL2 RL3
                  if (rep_go_on) begin
                     state_q <= ST_REP_TEST;
                  end else begin
                     state_q <= ST_DONE;
                  end
               end
            end
            ST_RET_IP: begin
               if (stack_rd_done) begin
                  // Pop the instruction pointer and step the stack; see RL6
                  ip_out_q <= stack_rd_data;
                  sp_out_q <= sp_popped;
                  // The code segment word sits at the stepped pointer.
                  stack_addr_q <= sp_popped;
                  if (ret_far_q) begin
                     state_q <= ST_RET_CS;
                  end else begin
                     state_q <= ST_RET_ADJ;
                  end
               end
            end
            ST_RET_CS: begin
               if (stack_rd_done) begin
                  // Far return pops the code segment too; see RL7
                  cs_out_q <= stack_rd_data;
                  cs_load_q <= 1'b1;
                  sp_out_q <= sp_popped;
                  state_q <= ST_RET_ADJ;
               end
            end
            ST_RET_ADJ: begin
               // Pop value applies after the address pops; see RL8
               if (ret_pop_q) begin
                  sp_out_q <= sp_adjusted;
               end
               state_q <= ST_DONE;
            end
            ST_ROTL: begin
               // A zero count goes straight to done and leaves every flag as it was.
               if (steps_q == 8'h00) begin
                  state_q <= ST_DONE;
               end else begin
                  // One rotate step per count; see RL9
                  rotl_result_q <= rot_next;
                  flags_out_q <= rot_flags_d;
                  steps_q <= steps_q - 8'h01;
               end
            end
            ST_DONE: begin
               // Done is a single pulse; the results stand until the next start.
               done_q <= 1'b1;
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

/* dv/rrx_exec_asserts.sv */
// Purpose: Concurrent checks on the ports of the repeat, return and rotate block.
// Assumes: One clock, synchronous active-high reset, starts taken while busy is low.
// Notes: Helper registers capture the operands of the started command.
`timescale 1ns/1ns
module rrx_exec_chk (
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // Commands
   input wire start_rep,
   input wire start_ret,
   input wire ret_far,
   input wire ret_has_pop,
   input wire [7:0] ret_pop_value,
   input wire start_rotl,
   input wire rotl_word,
   input wire [7:0] rotl_count,
   input wire [15:0] rotl_operand,
   input wire busy,
   input wire done_q,
   // State and handshakes
   input wire [15:0] count_in,
   input wire [15:0] sp_in,
   input wire [15:0] flags_in,
   input wire irq_service_req,
   input wire prim_req,
   input wire stack_rd_req,
   input wire [15:0] stack_addr_q,
   // Results
   input wire [15:0] sp_out_q,
   input wire cs_load_q,
   input wire [15:0] flags_out_q,
   input wire [15:0] rotl_result_q
);
   reg [1:0] k_q;
   reg [7:0] n_q;
   reg [15:0] f_q;
   reg [15:0] s_q;
   reg [15:0] o_q;
   reg w_q;
   reg far_q;
   wire go = !busy && (start_rep || start_ret || start_rotl);
   always @(posedge clk_sys) begin
      if (srst) begin
         k_q <= 2'h0;
      end else if (go) begin
         k_q <= start_rep ? 2'h1 : (start_ret ? 2'h2 : 2'h3);
         n_q <= rotl_count;
         f_q <= flags_in;
         o_q <= rotl_operand;
         w_q <= rotl_word;
         far_q <= ret_far;
         s_q <= sp_in + (ret_far ? 16'h0004 : 16'h0002) + (ret_has_pop ? {8'h00, ret_pop_value} : 16'h0000);
      end
   end
   wire hb = w_q ? rotl_result_q[15] : rotl_result_q[7];
   wire rot = done_q && k_q == 2'h3 && n_q != 8'h00;
   wire ret = done_q && k_q == 2'h2;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_no_prim2;
      !prim_req [*2];
   endsequence
   property p_rep_zero;
      go && start_rep && count_in == 16'h0000 |=> s_no_prim2 ##1 done_q;
   endproperty
   a_rep_zero: assert property (p_rep_zero) else $error("repeat with zero count ran a primitive");
   sequence s_irq_end;
      irq_service_req ##1 !irq_service_req;
   endsequence
   property p_prim_irq;
      s_irq_end |-> prim_req;
   endproperty
   a_prim_irq: assert property (p_prim_irq) else $error("primitive did not follow interrupt service");
   property p_rotl_one;
      go && start_rotl && !start_rep && !start_ret && rotl_word && rotl_count == 8'h01
         |-> ##4 done_q && rotl_result_q == {o_q[14:0], o_q[15]};
   endproperty
   a_rotl_one: assert property (p_rotl_one) else $error("single word rotate wrong");
   property p_rotl_cf;
      rot |-> flags_out_q[0] == rotl_result_q[0];
   endproperty
   a_rotl_cf: assert property (p_rotl_cf) else $error("carry not equal to low bit");
   property p_rotl_of;
      rot && n_q == 8'h01 |-> flags_out_q[11] == (hb ^ flags_out_q[0]);
   endproperty
   a_rotl_of: assert property (p_rotl_of) else $error("overflow wrong after single rotate");
   property p_rotl_keep;
      rot |-> (flags_out_q & 16'hf7fe) == (f_q & 16'hf7fe);
   endproperty
   a_rotl_keep: assert property (p_rotl_keep) else $error("rotate touched other flags");
   property p_ret_addr;
      go && start_ret && !start_rep |=> stack_rd_req && stack_addr_q == $past(sp_in);
   endproperty
   a_ret_addr: assert property (p_ret_addr) else $error("first pop not at stack top");
   property p_ret_cs;
      ret |-> cs_load_q == far_q;
   endproperty
   a_ret_cs: assert property (p_ret_cs) else $error("code segment load wrong");
   property p_ret_sp;
      ret |-> sp_out_q == s_q;
   endproperty
   a_ret_sp: assert property (p_ret_sp) else $error("stack pointer after return wrong");
   property p_ret_flags;
      ret |-> flags_out_q == f_q;
   endproperty
   a_ret_flags: assert property (p_ret_flags) else $error("return changed flags");
endmodule
bind rrx_exec rrx_exec_chk u_chk (.clk_sys, .srst, .start_rep, .start_ret, .ret_far, .ret_has_pop, .ret_pop_value,
   .start_rotl, .rotl_word, .rotl_count, .rotl_operand, .busy, .done_q, .count_in, .sp_in, .flags_in,
   .irq_service_req, .prim_req, .stack_rd_req, .stack_addr_q, .sp_out_q, .cs_load_q, .flags_out_q, .rotl_result_q);

/* dv/test_rrx_exec.sv */
// Purpose: Scenario bench for the repeat, return and rotate block.
// Assumes: Bench answers primitive, stack and interrupt requests itself.
// Notes: Stack word at address a reads as a xor 16'h1111.
`timescale 1ns/1ns
module test_rrx_exec;
   reg clk_sys = 1'h0, srst = 1'h1, start_rep = 1'h0, rep_while_zero = 1'h0, start_ret = 1'h0, ret_far = 1'h0;
   reg ret_has_pop = 1'h0, start_rotl = 1'h0, rotl_word = 1'h0, irq_pending = 1'h0, irq_service_done = 1'h0;
   reg prim_done = 1'h0, stack_rd_done = 1'h0;
   reg [1:0] prim_kind = 2'h0;
   reg [7:0] ret_pop_value = 8'h00, rotl_count = 8'h00;
   reg [15:0] rotl_operand = 16'h0, count_in = 16'h0, sp_in = 16'h0, flags_in = 16'h0, prim_flags = 16'h0;
   reg [15:0] stack_rd_data = 16'h0, zseq = 16'h0;
   wire busy, done_q, irq_service_req, prim_req, stack_rd_req, cs_load_q;
   wire [15:0] stack_addr_q, count_out_q, sp_out_q, ip_out_q, cs_out_q, flags_out_q, rotl_result_q;
   integer num_errors = 0, cmp_count = 0, np = 0, ni = 0;
   rrx_exec DUT (.clk_sys, .srst, .start_rep, .rep_while_zero, .prim_kind, .start_ret, .ret_far, .ret_has_pop,
      .ret_pop_value, .start_rotl, .rotl_word, .rotl_count, .rotl_operand, .busy, .done_q, .count_in, .sp_in,
      .flags_in, .irq_pending, .irq_service_req, .irq_service_done, .prim_req, .prim_done, .prim_flags,
      .stack_rd_req, .stack_addr_q, .stack_rd_done, .stack_rd_data, .count_out_q, .sp_out_q, .ip_out_q,
      .cs_out_q, .cs_load_q, .flags_out_q, .rotl_result_q);
   always #2 clk_sys = ~clk_sys;
   // Far side answers every request after one cycle; the idle stack read data toggles.
   always @(posedge clk_sys) begin
      prim_done <= prim_req && !prim_done;
      stack_rd_done <= stack_rd_req && !stack_rd_done;
      stack_rd_data <= (stack_rd_req && !stack_rd_done) ? stack_addr_q ^ 16'h1111 : ~stack_rd_data;
      irq_service_done <= irq_service_req && !irq_service_done;
      if (irq_service_req && !irq_service_done) begin
         irq_pending <= 1'h0;
         ni <= ni + 1;
      end
      if (prim_req && !prim_done) begin
         prim_flags <= {9'h000, zseq[np], 6'h00};
         np <= np + 1;
      end
   end
   task final_report;
      begin
         if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task run(input [2:0] k);
      integer i;
      begin
         {start_rep, start_ret, start_rotl} <= k;
         @(posedge clk_sys);
         {start_rep, start_ret, start_rotl} <= 3'h0;
         i = 0;
         while (done_q !== 1'h1 && i < 200) begin
            @(posedge clk_sys);
            #1;
            i = i + 1;
         end
         chk(done_q, 16'h1);
      end
   endtask
   task rot(input w, input [7:0] n, input [15:0] op, input [15:0] fi, input [15:0] er, input [15:0] ef);
      begin
         @(posedge clk_sys);
         rotl_word <= w;
         rotl_count <= n;
         rotl_operand <= op;
         flags_in <= fi;
         run(3'h1);
         chk(rotl_result_q, er);
         chk(flags_out_q, ef);
      end
   endtask
   task ret(input far, input hp, input [7:0] pv, input [15:0] esp);
      begin
         @(posedge clk_sys);
         ret_far <= far;
         ret_has_pop <= hp;
         ret_pop_value <= pv;
         sp_in <= 16'h0100;
         flags_in <= 16'h0ad5;
         run(3'h2);
         chk(ip_out_q, 16'h1011);
         chk(sp_out_q, esp);
         chk(cs_load_q, far);
         if (far)
            chk(cs_out_q, 16'h1013);
         chk(flags_out_q, 16'h0ad5);
      end
   endtask
   task repeat_prefix(input wz, input [1:0] pk, input [15:0] cnt, input [15:0] zs, input irq, input [15:0] ec, input [15:0] en);
      begin
         @(posedge clk_sys);
         rep_while_zero <= wz;
         prim_kind <= pk;
         count_in <= cnt;
         zseq <= zs;
         irq_pending <= irq;
         flags_in <= ~{9'h000, zs[0], 6'h00};
         np = 0;
         ni = 0;
         run(3'h4);
         chk(count_out_q, ec);
         chk(np, en);
         chk(ni, irq);
         if (cnt == 16'h0000)
            chk(flags_out_q, ~{9'h000, zs[0], 6'h00});
      end
   endtask
   initial begin
      #80000;
      num_errors = num_errors + 1;
      final_report;
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      srst <= 1'h0;
      rot(1'h1, 8'h01, 16'h4001, 16'h0fff, 16'h8002, 16'h0ffe);
      rot(1'h1, 8'h01, 16'h8000, 16'h0000, 16'h0001, 16'h0801);
      rot(1'h1, 8'h01, 16'hc000, 16'h0800, 16'h8001, 16'h0001);
      rot(1'h0, 8'h03, 16'h00a5, 16'h0000, 16'h002d, 16'h0001);
      rot(1'h0, 8'h00, 16'h00a5, 16'h0041, 16'h00a5, 16'h0041);
      ret(1'h0, 1'h0, 8'h00, 16'h0102);
      ret(1'h1, 1'h1, 8'h06, 16'h010a);
      ret(1'h0, 1'h1, 8'hff, 16'h0201);
      repeat_prefix(1'h1, 2'h0, 16'h0003, 16'h0000, 1'h1, 16'h0000, 16'h3);
      repeat_prefix(1'h1, 2'h1, 16'h0002, 16'h0000, 1'h0, 16'h0000, 16'h2);
      repeat_prefix(1'h1, 2'h2, 16'h0005, 16'h0003, 1'h0, 16'h0002, 16'h3);
      repeat_prefix(1'h1, 2'h2, 16'h0002, 16'hffff, 1'h0, 16'h0000, 16'h2);
      repeat_prefix(1'h0, 2'h3, 16'h0005, 16'h0002, 1'h1, 16'h0003, 16'h2);
      repeat_prefix(1'h0, 2'h3, 16'h0000, 16'h0000, 1'h0, 16'h0000, 16'h0);
      final_report;
   end
endmodule
